/* verilog/puic_regs.svh */
// Functional notes
// - direction pin rising edge selects infuse, falling edge selects refill.
// - trigger pin falling edge fires next program event; rising edge ignored.
// - momentary footswitch mode: each falling edge toggles run and stop.
// - level footswitch mode: rising edge starts, falling edge stops.
// - inverted footswitch mode: falling edge starts, rising edge stops.
// - both trigger outputs reset low, change only by software command.
// - sync output rises when infuse begins, falls when refill begins.
// - direction output high while refilling, low while infusing.
// - valve output high when actuated, low when off.
// - valve in auto setting follows every direction change.
// - run indicator is active low, low while motor runs.
// - analog mode samples input and updates rate every 100 ms.
// - each satellite status maps to its own colour code.
`ifndef PUIC_REGS_SVH
`define PUIC_REGS_SVH

// ---------------------------------------------------------------
// register byte offsets
// ---------------------------------------------------------------
`define PUIC_ADDR_CTRL 8'h00
`define PUIC_ADDR_CMD 8'h04
`define PUIC_ADDR_STATUS 8'h08
`define PUIC_ADDR_ISTAT 8'h0C
`define PUIC_ADDR_IMASK 8'h10
`define PUIC_ADDR_SAT 8'h14
`define PUIC_ADDR_RATE 8'h18

// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define PUIC_CTRL_FOOT_LSB 0
`define PUIC_CTRL_VALVE_LSB 2
`define PUIC_CTRL_ANALOG_BIT 4
`define PUIC_CTRL_TRIG1_BIT 5
`define PUIC_CTRL_TRIG2_BIT 6
`define PUIC_CMD_START_BIT 0
`define PUIC_CMD_STOP_BIT 1
`define PUIC_CMD_INFUSE_BIT 2
`define PUIC_CMD_REFILL_BIT 3
`define PUIC_EV_TRIG_BIT 0
`define PUIC_EV_RATE_BIT 1
`define PUIC_EV_DIR_BIT 2
`define PUIC_EV_RUN_BIT 3
`define PUIC_SAT0_LSB 0
`define PUIC_SAT1_LSB 2

// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define PUIC_IMASK_RESET 4'h0
`define PUIC_RATE_RESET 12'h000
`define PUIC_PIN_RESET 1'b1

// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define PUIC_CLK_HZ 200000000
`define PUIC_MIN_PULSE_MS 100
`define PUIC_SETTLE_MS 250
`define PUIC_ANALOG_CYCLE_MS 100
`define PUIC_ANALOG_CYCLE_CYC (`PUIC_ANALOG_CYCLE_MS * (`PUIC_CLK_HZ / 1000))
`define PUIC_PACER_W 25

`endif

/* verilog/puic_pkg.sv */
`include "puic_regs.svh"
package puic_pkg;

  // footswitch behaviour; every code is legal
  typedef enum logic [1:0] {
    FOOT_MOMENTARY = 2'b00,
    FOOT_LEVEL = 2'b01,
    FOOT_INVERTED = 2'b10,
    FOOT_OFF = 2'b11
  } puic_foot_mode_type;

  // valve setting; code 2'b11 is illegal, reads back as 2'b11 and drives the valve off
  typedef enum logic [1:0] {
    VALVE_OFF = 2'b00,
    VALVE_ON = 2'b01,
    VALVE_AUTO = 2'b10
  } puic_valve_mode_type;

  typedef enum logic [1:0] {
    SAT_STOPPED = 2'b00,
    SAT_COMM_ERR = 2'b01,
    SAT_STALL = 2'b10,
    SAT_RUNNING = 2'b11
  } puic_sat_status_type;

  typedef enum logic [1:0] {
    COLOUR_BLUE = 2'b00,
    COLOUR_RED = 2'b01,
    COLOUR_YELLOW = 2'b10,
    COLOUR_GREEN = 2'b11
  } puic_colour_type;

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic level;
    logic rise;
    logic fall;
  } puic_sync_state_type;

  typedef struct packed {
    logic [`PUIC_PACER_W-1:0] count;
    logic tick;
  } puic_pacer_state_type;

  typedef struct packed {
    puic_foot_mode_type foot_mode;
    puic_valve_mode_type valve_mode;
    logic analog_en;
    logic trig1;
    logic trig2;
    logic running;
    logic refill;
    logic valve;
    logic sync;
    logic run_n;
    logic prog_event;
    logic [3:0] istat;
    logic [3:0] imask;
    logic irq;
    puic_sat_status_type sat0;
    puic_sat_status_type sat1;
    puic_colour_type col0;
    puic_colour_type col1;
    logic [11:0] rate;
    logic rate_strobe;
    logic pready;
    logic [31:0] prdata;
    logic pslverr;
  } puic_state_type;

  // satellite status to display colour
  function automatic puic_colour_type puic_colour_of(input puic_sat_status_type st);
    unique case (st)
      SAT_STOPPED: puic_colour_of = COLOUR_BLUE;
      SAT_COMM_ERR: puic_colour_of = COLOUR_RED;
      SAT_STALL: puic_colour_of = COLOUR_YELLOW;
      SAT_RUNNING: puic_colour_of = COLOUR_GREEN;
    endcase
  endfunction

endpackage

/* verilog/puic_input_sync.sv */
`timescale 1ns/1ps
`include "puic_regs.svh"
module puic_input_sync (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // pin side
  input wire logic pin,
  // edge events
  output logic rise,
  output logic fall
);
  import puic_pkg::*;

  puic_sync_state_type s;
  puic_sync_state_type next_s;

  // three stages; level moves only once stages two and three agree
  always_comb begin
    next_s = s;
    next_s.s1 = pin;
    next_s.s2 = s.s1;
    next_s.s3 = s.s2;
    if (s.s2 == s.s3) begin
      next_s.level = s.s3;
    end
    next_s.rise = next_s.level & ~s.level;
    next_s.fall = ~next_s.level & s.level;
  end

  // inputs idle high through pull-ups, so reset to high
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= {{4{`PUIC_PIN_RESET}}, 2'b00};
    end else begin
      s <= next_s;
    end
  end

  assign rise = s.rise;
  assign fall = s.fall;

  a_edge_single: assert property (@(posedge pclk) disable iff (!presetn)
    (rise || fall) |=> !(rise || fall)) else $error("edge event longer than one cycle");

endmodule // puic_input_sync

/* verilog/puic_rate_pacer.sv */
`timescale 1ns/1ps
`include "puic_regs.svh"
module puic_rate_pacer #(
  parameter int unsigned CYCLES = `PUIC_ANALOG_CYCLE_CYC
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // control
  input wire logic enable,
  // one pulse per period
  output logic tick
);
  import puic_pkg::*;

  localparam logic [`PUIC_PACER_W-1:0] LAST = `PUIC_PACER_W'(CYCLES - 1);

  puic_pacer_state_type s;
  puic_pacer_state_type next_s;

  // free count while enabled; restarts from zero on enable
  always_comb begin
    next_s = s;
    next_s.tick = 1'b0;
    if (!enable) begin
      next_s.count = '0;
    end else if (s.count == LAST) begin
      next_s.count = '0;
      next_s.tick = 1'b1;
    end else begin
      next_s.count = s.count + `PUIC_PACER_W'(1);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign tick = s.tick;

  a_tick_period: assert property (@(posedge pclk) disable iff (!presetn)
    tick |-> $past(s.count) == LAST) else $error("rate tick off its period");

endmodule // puic_rate_pacer

/* verilog/puic_top.sv */
// The implementer's own choices: the APB register port and the address map.
`timescale 1ns/1ps
`include "puic_regs.svh"
module puic_top #(
  parameter int unsigned ANALOG_CYCLES = `PUIC_ANALOG_CYCLE_CYC
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  // user input pins
  input wire logic dir_in,
  input wire logic trig_in,
  input wire logic foot_in,
  // analog converter result
  input wire logic [11:0] analog_code,
  // user output pins
  output logic trig1_out,
  output logic trig2_out,
  output logic sync_out,
  output logic dir_out,
  output logic valve_out,
  output logic run_ind_n,
  // pump side
  output logic program_event,
  output logic [11:0] rate_value,
  output logic rate_strobe,
  output puic_pkg::puic_colour_type sat0_colour,
  output puic_pkg::puic_colour_type sat1_colour,
  // interrupt
  output logic irq
);
  import puic_pkg::*;

  // ---------------------------------------------------------------
  // input synchronisers and rate pacer
  // ---------------------------------------------------------------
  logic dir_rise;
  logic dir_fall;
  logic trig_rise;
  logic trig_fall;
  logic foot_rise;
  logic foot_fall;
  logic rate_tick;

  puic_input_sync u_dir_sync (
    .pclk(pclk),
    .presetn(presetn),
    .pin(dir_in),
    .rise(dir_rise),
    .fall(dir_fall)
  );

  puic_input_sync u_trig_sync (
    .pclk(pclk),
    .presetn(presetn),
    .pin(trig_in),
    .rise(trig_rise),
    .fall(trig_fall)
  );

  puic_input_sync u_foot_sync (
    .pclk(pclk),
    .presetn(presetn),
    .pin(foot_in),
    .rise(foot_rise),
    .fall(foot_fall)
  );

  puic_state_type s;
  puic_state_type next_s;

  puic_rate_pacer #(
    .CYCLES(ANALOG_CYCLES)
  ) u_pacer (
    .pclk(pclk),
    .presetn(presetn),
    .enable(s.analog_en),
    .tick(rate_tick)
  );

  // ---------------------------------------------------------------
  // bus decode
  // ---------------------------------------------------------------
  logic access;
  logic wr_now;
  logic hit;
  logic [31:0] rd_word;
  logic cmd_wr;
  logic ctrl_wr;

  // one wait state so read data leaves a flip-flop
  assign access = psel & penable & ~s.pready;
  assign wr_now = psel & penable & s.pready & pwrite;
  assign cmd_wr = wr_now & (paddr == `PUIC_ADDR_CMD);
  assign ctrl_wr = wr_now & (paddr == `PUIC_ADDR_CTRL);

  // read mux; command register reads zero
  always_comb begin
    hit = 1'b1;
    rd_word = 32'h0000_0000;
    unique case (paddr)
      `PUIC_ADDR_CTRL: begin
        rd_word = {25'h000_0000, s.trig2, s.trig1, s.analog_en, s.valve_mode, s.foot_mode};
      end
      `PUIC_ADDR_CMD: begin
        rd_word = 32'h0000_0000;
      end
      `PUIC_ADDR_STATUS: begin
        rd_word = {27'h000_0000, s.trig2, s.trig1, s.valve, s.refill, s.running};
      end
      `PUIC_ADDR_ISTAT: begin
        rd_word = {28'h000_0000, s.istat};
      end
      `PUIC_ADDR_IMASK: begin
        rd_word = {28'h000_0000, s.imask};
      end
      `PUIC_ADDR_SAT: begin
        rd_word = {28'h000_0000, s.sat1, s.sat0};
      end
      `PUIC_ADDR_RATE: begin
        rd_word = {20'h0_0000, s.rate};
      end
      default: begin
        hit = 1'b0;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  logic run_v;
  logic refill_v;
  logic [3:0] events;
  logic [3:0] clr;

  always_comb begin
    next_s = s;
    next_s.prog_event = 1'b0;
    next_s.rate_strobe = 1'b0;
    next_s.pslverr = 1'b0;
    next_s.pready = access;
    if (access) begin
      next_s.prdata = rd_word;
      next_s.pslverr = ~hit;
    end
    clr = 4'h0;

    // software-owned registers
    if (ctrl_wr) begin
      next_s.foot_mode = puic_foot_mode_type'(pwdata[`PUIC_CTRL_FOOT_LSB +: 2]);
      next_s.valve_mode = puic_valve_mode_type'(pwdata[`PUIC_CTRL_VALVE_LSB +: 2]);
      next_s.analog_en = pwdata[`PUIC_CTRL_ANALOG_BIT];
      next_s.trig1 = pwdata[`PUIC_CTRL_TRIG1_BIT];
      next_s.trig2 = pwdata[`PUIC_CTRL_TRIG2_BIT];
    end
    if (wr_now && paddr == `PUIC_ADDR_IMASK) begin
      next_s.imask = pwdata[3:0];
    end
    if (wr_now && paddr == `PUIC_ADDR_SAT) begin
      next_s.sat0 = puic_sat_status_type'(pwdata[`PUIC_SAT0_LSB +: 2]);
      next_s.sat1 = puic_sat_status_type'(pwdata[`PUIC_SAT1_LSB +: 2]);
    end
    if (wr_now && paddr == `PUIC_ADDR_ISTAT) begin
      clr = pwdata[3:0];
    end

    // run state: command first, footswitch edge has the last word
    run_v = s.running;
    if (cmd_wr && pwdata[`PUIC_CMD_START_BIT]) begin
      run_v = 1'b1;
    end
    if (cmd_wr && pwdata[`PUIC_CMD_STOP_BIT]) begin
      run_v = 1'b0;
    end
    unique case (s.foot_mode)
      FOOT_MOMENTARY: begin
        if (foot_fall) begin
          run_v = ~run_v;
        end
      end
      FOOT_LEVEL: begin
        if (foot_rise) begin
          run_v = 1'b1;
        end else if (foot_fall) begin
          run_v = 1'b0;
        end
      end
      FOOT_INVERTED: begin
        if (foot_fall) begin
          run_v = 1'b1;
        end else if (foot_rise) begin
          run_v = 1'b0;
        end
      end
      FOOT_OFF: begin
        run_v = run_v;
      end
    endcase

    // direction: the pin edge overrides a command in the same cycle
    refill_v = s.refill;
    if (cmd_wr && pwdata[`PUIC_CMD_INFUSE_BIT]) begin
      refill_v = 1'b0;
    end
    if (cmd_wr && pwdata[`PUIC_CMD_REFILL_BIT]) begin
      refill_v = 1'b1;
    end
    if (dir_rise) begin
      refill_v = 1'b0;
    end else if (dir_fall) begin
      refill_v = 1'b1;
    end

    next_s.running = run_v;
    next_s.run_n = ~run_v;
    next_s.refill = refill_v;
    // sync moves only on a phase change, so it stays low until the first change from refill to infuse
    if (s.refill && !refill_v) begin
      next_s.sync = 1'b1;
    end else if (!s.refill && refill_v) begin
      next_s.sync = 1'b0;
    end

    // valve; an illegal setting keeps the valve off
    unique case (next_s.valve_mode)
      VALVE_ON: next_s.valve = 1'b1;
      VALVE_AUTO: next_s.valve = refill_v;
      default: next_s.valve = 1'b0;
    endcase

    // program event on falling trigger edge only
    next_s.prog_event = trig_fall;

    // analog rate update once per pacer period
    if (rate_tick && s.analog_en) begin
      next_s.rate = analog_code;
      next_s.rate_strobe = 1'b1;
    end

    // satellite colours
    next_s.col0 = puic_colour_of(next_s.sat0);
    next_s.col1 = puic_colour_of(next_s.sat1);

    // sticky events; a new event wins over a clear in the same cycle
    events = 4'h0;
    events[`PUIC_EV_TRIG_BIT] = trig_fall;
    events[`PUIC_EV_RATE_BIT] = rate_tick & s.analog_en;
    events[`PUIC_EV_DIR_BIT] = refill_v ^ s.refill;
    events[`PUIC_EV_RUN_BIT] = run_v ^ s.running;
    next_s.istat = (s.istat & ~clr) | events;
    next_s.irq = |(next_s.istat & next_s.imask);
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
      s.foot_mode <= FOOT_MOMENTARY;
      s.valve_mode <= VALVE_OFF;
      s.run_n <= 1'b1;
      s.imask <= `PUIC_IMASK_RESET;
      s.rate <= `PUIC_RATE_RESET;
      s.col0 <= COLOUR_BLUE;
      s.col1 <= COLOUR_BLUE;
    end else begin
      s <= next_s;
    end
  end

  // outputs straight from the state register
  assign pready = s.pready;
  assign prdata = s.prdata;
  assign pslverr = s.pslverr;
  assign trig1_out = s.trig1;
  assign trig2_out = s.trig2;
  assign sync_out = s.sync;
  assign dir_out = s.refill;
  assign valve_out = s.valve;
  assign run_ind_n = s.run_n;
  assign program_event = s.prog_event;
  assign rate_value = s.rate;
  assign rate_strobe = s.rate_strobe;
  assign sat0_colour = s.col0;
  assign sat1_colour = s.col1;
  assign irq = s.irq;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_dir_infuse: assert property (dir_rise |=> !dir_out)
    else $error("rising direction edge did not select infuse");
  a_dir_refill: assert property (dir_fall |=> dir_out)
    else $error("falling direction edge did not select refill");
  a_trig_event: assert property (trig_fall |=> program_event ##1 !program_event)
    else $error("trigger fall gave no single event");
  a_trig_rise_quiet: assert property (trig_rise |=> !program_event)
    else $error("trigger rise gave an event");
  a_foot_toggle: assert property ((s.foot_mode == FOOT_MOMENTARY) && foot_fall && !cmd_wr
    |=> run_ind_n != $past(run_ind_n)) else $error("momentary edge did not toggle");
  a_foot_level: assert property ((s.foot_mode == FOOT_LEVEL) && foot_rise |=> !run_ind_n)
    else $error("level mode rise did not start");
  a_foot_invert: assert property ((s.foot_mode == FOOT_INVERTED) && foot_fall |=> !run_ind_n)
    else $error("inverted mode fall did not start");
  a_trig_hold: assert property (!ctrl_wr |=> $stable({trig1_out, trig2_out}))
    else $error("trigger output moved without command");
  a_sync_edge: assert property ($rose(sync_out) |-> !dir_out && $past(dir_out))
    else $error("sync rose outside infuse start");
  a_sync_fall: assert property ($fell(sync_out) |-> dir_out && !$past(dir_out))
    else $error("sync fell outside refill start");
  a_valve_on: assert property ((s.valve_mode == VALVE_ON) |-> valve_out)
    else $error("actuated valve output low");
  a_valve_auto: assert property ((s.valve_mode == VALVE_AUTO) |-> valve_out == dir_out)
    else $error("auto valve not tracking direction");
  a_run_ind: assert property ($changed(run_ind_n) |-> s.istat[`PUIC_EV_RUN_BIT])
    else $error("run indicator moved without run change");
  a_rate_take: assert property (rate_strobe |-> rate_value == $past(analog_code))
    else $error("rate update took wrong sample");
  a_sat_colour: assert property (sat0_colour == puic_colour_of(s.sat0))
    else $error("satellite colour mismatch");

  c_foot_toggle: cover property ((s.foot_mode == FOOT_MOMENTARY) && foot_fall ##1 !run_ind_n);
  c_program_event: cover property (program_event);
  c_rate_update: cover property (rate_strobe);
  c_irq: cover property ($rose(irq));

endmodule // puic_top

/* dv/puic_io_partner.sv */
`timescale 1ns/1ps
module puic_io_partner #(
  parameter int HOLD = 8,
  parameter int SETTLE = 40
) (
  // clock
  input wire logic pclk,
  // pins toward the pump
  output logic dir_in,
  output logic trig_in,
  output logic foot_in,
  output logic [11:0] analog_code
);
  // ---------------------------------------------
  // idle levels
  // ---------------------------------------------
  // inputs idle at the pull-up level, analog source starts at zero volts
  initial begin
    dir_in = 1'b1;
    trig_in = 1'b1;
    foot_in = 1'b1;
    analog_code = 12'h000;
  end

  // ---------------------------------------------
  // stimulus steps
  // ---------------------------------------------
  // each pin level is held long enough for the pump to see it
  task automatic set_pin(input int which, input logic val);
    @(posedge pclk);
    case (which)
      0: dir_in <= val;
      1: trig_in <= val;
      default: foot_in <= val;
    endcase
    repeat (HOLD) @(posedge pclk);
  endtask

  // a new control voltage is given time to settle before anyone looks
  task automatic set_level(input logic [11:0] code);
    @(posedge pclk);
    analog_code <= code;
    repeat (SETTLE) @(posedge pclk);
  endtask
endmodule // puic_io_partner

/* dv/tb.sv */
`timescale 1ns/1ps
`include "puic_regs.svh"
module tb;
  import puic_pkg::*;
  localparam int ACYC = 20;
  // footswitch walk: mode and expected run indicator, pin alternates 0/1
  localparam logic [1:0] FM [12] = '{0, 0, 0, 0, 1, 1, 1, 2, 2, 2, 3, 3};
  localparam logic FE [12] = '{0, 0, 1, 1, 1, 0, 1, 1, 0, 1, 1, 1};
  localparam puic_colour_type CT [4] = '{COLOUR_BLUE, COLOUR_RED, COLOUR_YELLOW, COLOUR_GREEN};
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic dir_in, trig_in, foot_in, trig1_out, trig2_out, sync_out, dir_out, valve_out;
  logic run_ind_n, program_event, rate_strobe, irq;
  logic [11:0] analog_code, rate_value;
  puic_colour_type sat0_colour, sat1_colour;
  int bad_count = 0;
  int checks_done = 0;
  int ev_count = 0;
  int st_count = 0;
  int cyc = 0;
  int last_st = 0;
  int gap = 0;
  int e0;

  puic_top #(.ANALOG_CYCLES(ACYC)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .dir_in(dir_in), .trig_in(trig_in),
    .foot_in(foot_in), .analog_code(analog_code), .trig1_out(trig1_out),
    .trig2_out(trig2_out), .sync_out(sync_out), .dir_out(dir_out), .valve_out(valve_out),
    .run_ind_n(run_ind_n), .program_event(program_event), .rate_value(rate_value),
    .rate_strobe(rate_strobe), .sat0_colour(sat0_colour), .sat1_colour(sat1_colour),
    .irq(irq));
  puic_io_partner part (.pclk(pclk), .dir_in(dir_in), .trig_in(trig_in),
    .foot_in(foot_in), .analog_code(analog_code));

  // ---------------------------------------------
  // clock and event counters
  // ---------------------------------------------
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  // pulse counts give single-cycle events away if they stretch
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (program_event === 1'b1) begin
      ev_count <= ev_count + 1;
    end
    if (rate_strobe === 1'b1) begin
      gap <= cyc - last_st;
      last_st <= cyc;
      st_count <= st_count + 1;
    end
  end

  // ---------------------------------------------
  // shared tasks
  // ---------------------------------------------
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // one apb transfer; request held until pready is seen at an edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      bad_count++;
      complete_run();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    repeat (2) @(posedge pclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  // ---------------------------------------------
  // main sequence
  // ---------------------------------------------
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    check("trig outs", {trig1_out, trig2_out}, 0);
    check("run_ind_n", run_ind_n, 1);
    check("dir sync valve", {dir_out, sync_out, valve_out}, 0);
    check("colours", {sat0_colour, sat1_colour}, 0);
    apb(1'b0, `PUIC_ADDR_IMASK, 0);
    check("imask reset", rd, 0);
    apb(1'b0, 8'h1C, 0);
    check("unmapped err", err, 1);
    check("unmapped read", rd, 0);
    $display("test reset done");
    // both trigger levels follow software alone
    for (int i = 0; i < 4; i++) begin
      wr(`PUIC_ADDR_CTRL, i << 5);
      check("trig outs", {trig2_out, trig1_out}, i);
    end
    // mid-run reset with both triggers high; pins idle high, so no false edge
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    check("trig after reset", {trig2_out, trig1_out}, 0);
    check("run_ind_n after reset", run_ind_n, 1);
    $display("test triggers done");
    // direction pin with valve on auto, two full cycles
    wr(`PUIC_ADDR_CTRL, 32'h0000_0008);
    for (int i = 0; i < 4; i++) begin
      part.set_pin(0, i[0]);
      check("dir_out", dir_out, !i[0]);
      check("sync_out", sync_out, i[0]);
      check("valve auto", valve_out, !i[0]);
    end
    wr(`PUIC_ADDR_CTRL, 32'h0000_0004);
    check("valve on", valve_out, 1);
    wr(`PUIC_ADDR_CTRL, 32'h0000_0000);
    check("valve off", valve_out, 0);
    $display("test direction done");
    e0 = ev_count;
    part.set_pin(1, 1'b0);
    check("event count", ev_count - e0, 1);
    part.set_pin(1, 1'b1);
    check("event count", ev_count - e0, 1);
    $display("test event trigger done");
    // every footswitch mode, including the ignored one
    for (int i = 0; i < 12; i++) begin
      wr(`PUIC_ADDR_CTRL, FM[i]);
      part.set_pin(2, i[0]);
      check("run_ind_n", run_ind_n, FE[i]);
    end
    $display("test footswitch done");
    apb(1'b0, `PUIC_ADDR_ISTAT, 0);
    check("istat run", {rd[3], irq}, 2'b10);
    wr(`PUIC_ADDR_CTRL, 0);
    wr(`PUIC_ADDR_ISTAT, 32'h0000_000F);
    wr(`PUIC_ADDR_IMASK, 32'h0000_0008);
    check("irq idle", irq, 0);
    part.set_pin(2, 1'b0);
    check("irq raised", {irq, run_ind_n}, 2'b10);
    wr(`PUIC_ADDR_ISTAT, 32'h0000_0008);
    apb(1'b0, `PUIC_ADDR_ISTAT, 0);
    check("irq cleared", {rd[3], irq}, 0);
    part.set_pin(2, 1'b1);
    $display("test interrupt done");
    // command register: stop beats start, software sets direction
    wr(`PUIC_ADDR_CMD, 32'h0000_000A);
    check("cmd stop refill", {run_ind_n, dir_out, sync_out}, 3'b110);
    apb(1'b0, `PUIC_ADDR_STATUS, 0);
    check("status", rd, 32'h0000_0002);
    wr(`PUIC_ADDR_CMD, 32'h0000_0005);
    check("cmd start infuse", {run_ind_n, dir_out, sync_out}, 3'b001);
    wr(`PUIC_ADDR_CMD, 32'h0000_0003);
    check("cmd stop wins", run_ind_n, 1);
    $display("test command done");
    for (int s = 0; s < 4; s++) begin
      wr(`PUIC_ADDR_SAT, ((3 - s) << 2) | s);
      check("sat0 colour", sat0_colour, CT[s]);
      check("sat1 colour", sat1_colour, CT[3 - s]);
    end
    $display("test satellite done");
    // analog pacing: spacing of strobes and the sampled code
    part.set_level(12'h5A3);
    wr(`PUIC_ADDR_CTRL, 32'h0000_0010);
    for (int n = 0; st_count < 3; n++) begin
      @(posedge pclk);
      if (n == 200) begin
        bad_count++;
        complete_run();
      end
    end
    check("rate gap", gap, ACYC);
    check("rate value", rate_value, 12'h5A3);
    apb(1'b0, `PUIC_ADDR_RATE, 0);
    check("rate reg", rd, 32'h0000_05A3);
    wr(`PUIC_ADDR_CTRL, 0);
    e0 = st_count;
    repeat (3 * ACYC) @(posedge pclk);
    check("rate stopped", st_count - e0, 0);
    $display("test analog done");
    complete_run();
  end
endmodule // tb
